// ===== core/cwd_pkg.sv
// Package of constants and types for the configuration word decoder.
package cwd_pkg;
  localparam int WORD_W = 14;
  localparam logic [31:0] APB_CONFIG_WORD = 32'h0000_0000;
  localparam logic [31:0] APB_PROG_CTRL = 32'h0000_0004;
  localparam logic [31:0] APB_PROG_ADDR = 32'h0000_0008;
  localparam logic [31:0] APB_PROG_DATA = 32'h0000_000C;
  localparam logic [31:0] APB_STATUS = 32'h0000_0010;
  localparam logic [31:0] APB_WAKE_CTRL = 32'h0000_0014;
  localparam logic [13:0] CONFIG_ADDR = 14'h2007;
  localparam logic [13:0] TEST_SPACE_LO = 14'h2000;
  localparam logic [13:0] TEST_SPACE_HI = 14'h3FFF;
  localparam logic [13:0] CONFIG_RESET = 14'h3FFF;
  localparam int OSC_SEL_LSB = 0;
  localparam int WATCHDOG_BIT = 2;
  localparam int PWRUP_OFF_BIT = 3;
  localparam int GUARD_LSB = 4;
  localparam int BROWNOUT_BIT = 6;
  localparam int UNUSED_BIT = 7;
  localparam logic [13:0] UNUSED_MASK_A = 14'h3FE0;
  localparam logic [13:0] UNUSED_MASK_B = 14'h0080;
  localparam real CLK_MHZ = 200.0;
  localparam real PWRUP_DELAY_MS = 72.0;
  localparam int PWRUP_CYCLES = int'(PWRUP_DELAY_MS * 1000.0 * CLK_MHZ);
  localparam int SETTLE_EDGES = 1024;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    CWD_OSC_LP,
    CWD_OSC_XT,
    CWD_OSC_HS,
    CWD_OSC_RC
  } cwd_osc_e;
  typedef enum logic [1:0] {
    CWD_GUARD_ALL,
    CWD_GUARD_UPPER34,
    CWD_GUARD_UPPER12,
    CWD_GUARD_NONE
  } cwd_guard_e;
endpackage : cwd_pkg

// ===== core/cwd_sync_counter.sv
// Edge counter fed by a two-flop synchronised pin, used for oscillator settling.
`timescale 1ns/100ps
module cwd_sync_counter #(
  parameter int COUNT = 1024
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  input wire logic start,
  output logic done
);
  import cwd_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic running;
    logic done;
    logic [$clog2(COUNT+1)-1:0] count;
  } cwd_cnt_s;

  cwd_cnt_s state;
  cwd_cnt_s next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Only the second synchroniser stage feeds the edge detector.
  always_comb begin
    next_state = state;
    next_state.sync1 = pinIn;
    next_state.sync2 = state.sync1;
    next_state.last = state.sync2;
    if (start) begin
      next_state.running = 1'b1;
      next_state.done = 1'b0;
      next_state.count = '0;
    end else if (state.running && state.sync2 && !state.last) begin
      if (state.count == ($clog2(COUNT+1))'(COUNT - 1)) begin
        next_state.running = 1'b0;
        next_state.done = 1'b1;
      end
      next_state.count = state.count + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign done = state.done;

  a_settle_count: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(state.done) |-> state.count == ($clog2(COUNT+1))'(COUNT))
    else $error("settle count finished at wrong edge");
endmodule : cwd_sync_counter

// ===== core/cwd_config_decoder.sv
// Configuration word decoder with programming port, power-up and settle timers.
`timescale 1ns/100ps
module cwd_config_decoder #(
  parameter int PWRUP_COUNT = cwd_pkg::PWRUP_CYCLES,
  parameter logic HAS_BROWNOUT = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic progModePin,
  input wire logic powerOnPin,
  input wire logic extResetPin,
  input wire logic watchdogWake,
  input wire logic irqPending,
  input wire logic oscInputPin,
  output cwd_pkg::cwd_osc_e oscType,
  output logic watchdogOn,
  output logic watchdogClkSel,
  output logic powerupDelayOn,
  output cwd_pkg::cwd_guard_e codeGuard,
  output logic brownoutOn,
  output logic extClockOk,
  output logic holdInReset,
  output logic powerDown
);
  import cwd_pkg::*;

  typedef enum logic [2:0] {
    CWD_ST_LOAD,
    CWD_ST_PWRUP,
    CWD_ST_SETTLE,
    CWD_ST_RUN,
    CWD_ST_SLEEP
  } cwd_seq_e;

  typedef struct packed {
    logic [WORD_W-1:0] configWord;
    logic [WORD_W-1:0] liveWord;
    logic [13:0] progAddr;
    logic [13:0] progData;
    logic sleepReq;
    cwd_seq_e seq;
    logic [31:0] timer;
    logic settleStart;
    logic [1:0] progSync;
    logic [1:0] porSync;
    logic [1:0] extSync;
    logic [31:0] rdata;
    logic slverr;
    logic accessDenied;
  } cwd_top_s;

  cwd_top_s state;
  cwd_top_s next_state;
  logic settleDone;
  logic inProg;
  logic powerOn;
  logic extReset;
  logic apbAccess;
  logic crystalMode;
  logic [13:0] readWord;

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised pins; first flops are read only by the second ones.
  assign inProg = state.progSync[1];
  assign powerOn = state.porSync[1];
  assign extReset = state.extSync[1];
  assign apbAccess = psel && penable;

  // Stored word with UNUSED_MASK_B (bit 7) forced to one on readback, or UNUSED_MASK_A (bits 13:5) without brownout.
  always_comb begin
    readWord = state.liveWord | UNUSED_MASK_A;
    if (HAS_BROWNOUT) begin
      readWord = state.liveWord | UNUSED_MASK_B;
    end
  end

  // Crystal modes need the settle count, except on leaving load without power-on; the RC mode starts at once.
  assign crystalMode = state.configWord[OSC_SEL_LSB +: 2] != 2'b11;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator settle counter on the oscillator input pin.
  cwd_sync_counter #(
    .COUNT(SETTLE_EDGES)
  ) u_settle (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(oscInputPin),
    .start(state.settleStart),
    .done(settleDone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for bus, programming port and reset sequencer.
  always_comb begin
    next_state = state;
    next_state.progSync = {state.progSync[0], progModePin};
    next_state.porSync = {state.porSync[0], powerOnPin};
    next_state.extSync = {state.extSync[0], extResetPin};
    next_state.settleStart = 1'b0;
    next_state.accessDenied = 1'b0;
    // Register reads are taken in the setup cycle so data is ready at access.
    // The error flag is cleared only in setup, so a setup-time error still stands at the access edge.
    if (psel && !penable) begin
      next_state.slverr = 1'b0;
      next_state.rdata = BAD_ADDR_DATA;
      if (paddr == APB_CONFIG_WORD) begin
        next_state.rdata = {18'h0_0000, readWord};
      end else if (paddr == APB_PROG_CTRL) begin
        next_state.rdata = {31'h0000_0000, inProg};
      end else if (paddr == APB_PROG_ADDR) begin
        next_state.rdata = {18'h0_0000, state.progAddr};
      end else if (paddr == APB_PROG_DATA) begin
        // Only the config word of test space is read back, and only while programming.
        if (inProg && state.progAddr == CONFIG_ADDR) begin
          next_state.rdata = {18'h0_0000, readWord};
        end else if (!inProg && state.progAddr >= TEST_SPACE_LO) begin
          next_state.slverr = 1'b1;
        end
      end else if (paddr == APB_STATUS) begin
        next_state.rdata = {27'h000_0000, settleDone, holdInReset, powerDown,
          inProg, crystalMode};
      end else if (paddr == APB_WAKE_CTRL) begin
        next_state.rdata = {31'h0000_0000, state.sleepReq};
      end else begin
        next_state.slverr = 1'b1;
      end
    end
    if (apbAccess && pwrite) begin
      if (paddr == APB_PROG_ADDR) begin
        next_state.progAddr = pwdata[13:0];
      end else if (paddr == APB_PROG_DATA) begin
        // Writes to the config word land only in programming mode.
        if (inProg && state.progAddr == CONFIG_ADDR) begin
          next_state.liveWord = pwdata[13:0];
        end else if (state.progAddr >= TEST_SPACE_LO) begin
          next_state.accessDenied = 1'b1;
        end
      end else if (paddr == APB_WAKE_CTRL) begin
        next_state.sleepReq = pwdata[0];
      end
    end
    if (apbAccess && pwrite && paddr == APB_PROG_DATA && state.accessDenied) begin
      next_state.slverr = 1'b1;
    end
    // Reset sequencer: power-up delay, then settle count, then run.
    case (state.seq)
      CWD_ST_LOAD: begin
        next_state.configWord = readWord;
        next_state.timer = '0;
        if (!extReset && !inProg) begin
          if (powerOn && !state.configWord[PWRUP_OFF_BIT]) begin
            next_state.seq = CWD_ST_PWRUP;
          end else if (powerOn && crystalMode) begin
            next_state.seq = CWD_ST_SETTLE;
            next_state.settleStart = 1'b1;
          end else begin
            next_state.seq = CWD_ST_RUN;
          end
        end
      end
      CWD_ST_PWRUP: begin
        next_state.timer = state.timer + 32'h0000_0001;
        if (state.timer == 32'(PWRUP_COUNT - 1)) begin
          next_state.timer = '0;
          if (crystalMode) begin
            next_state.seq = CWD_ST_SETTLE;
            next_state.settleStart = 1'b1;
          end else begin
            next_state.seq = CWD_ST_RUN;
          end
        end
      end
      CWD_ST_SETTLE: begin
        if (settleDone && !state.settleStart) begin
          next_state.seq = CWD_ST_RUN;
        end
      end
      CWD_ST_RUN: begin
        if (state.sleepReq) begin
          next_state.seq = CWD_ST_SLEEP;
          next_state.sleepReq = 1'b0;
        end
      end
      CWD_ST_SLEEP: begin
        // Any of three causes ends power-down; crystal modes resettle, but an external reset returns to the load state instead.
        if (extReset || watchdogWake || irqPending) begin
          next_state.seq = crystalMode ? CWD_ST_SETTLE : CWD_ST_RUN;
          next_state.settleStart = crystalMode;
        end
      end
      default: begin
        next_state.seq = CWD_ST_LOAD;
      end
    endcase
    // External reset or programming returns to the load state.
    if (extReset || inProg) begin
      next_state.seq = CWD_ST_LOAD;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= '0;
      state.configWord <= CONFIG_RESET;
      state.liveWord <= CONFIG_RESET;
      state.seq <= CWD_ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded selections come from the word latched in reset, never live writes.
  assign oscType = cwd_osc_e'(state.configWord[OSC_SEL_LSB +: 2]);
  assign watchdogOn = state.configWord[WATCHDOG_BIT];
  assign watchdogClkSel = 1'b1; // Always the private RC clock.
  assign powerupDelayOn = !state.configWord[PWRUP_OFF_BIT];
  assign codeGuard = cwd_guard_e'(state.configWord[GUARD_LSB +: 2]);
  assign brownoutOn = HAS_BROWNOUT && state.configWord[BROWNOUT_BIT];
  assign extClockOk = crystalMode;
  assign holdInReset = state.seq inside {CWD_ST_LOAD, CWD_ST_PWRUP, CWD_ST_SETTLE};
  assign powerDown = state.seq == CWD_ST_SLEEP;
  assign prdata = state.rdata;
  assign pready = 1'b1;
  assign pslverr = apbAccess && state.slverr;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on decoding and sequencing.
  sequence s_pwrup_start;
    state.seq == CWD_ST_LOAD ##1 state.seq == CWD_ST_PWRUP;
  endsequence

  a_word_ones: assert property (@(posedge clk) disable iff (sys_rst)
    readWord[UNUSED_BIT] == 1'b1)
    else $error("unimplemented bit read as zero");
  a_osc_decode: assert property (@(posedge clk) disable iff (sys_rst)
    (state.configWord[1:0] == 2'b11) == (oscType == CWD_OSC_RC))
    else $error("oscillator decode wrong");
  a_guard_decode: assert property (@(posedge clk) disable iff (sys_rst)
    (state.configWord[5:4] == 2'b00) == (codeGuard == CWD_GUARD_ALL))
    else $error("guard decode wrong");
  a_watchdog_bit: assert property (@(posedge clk) disable iff (sys_rst)
    watchdogOn == state.configWord[2])
    else $error("watchdog enable mismatch");
  a_pwrup_polarity: assert property (@(posedge clk) disable iff (sys_rst)
    s_pwrup_start |-> !state.configWord[3])
    else $error("power-up delay ran while disabled");
  a_pwrup_hold: assert property (@(posedge clk) disable iff (sys_rst)
    s_pwrup_start |-> holdInReset [*8])
    else $error("reset released during power-up delay");
  a_prog_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !inProg |=> $stable(state.liveWord))
    else $error("config word changed outside programming");
  a_stable_run: assert property (@(posedge clk) disable iff (sys_rst)
    !holdInReset && !$past(holdInReset) |-> $stable(state.configWord))
    else $error("selections changed while running");
  a_wake_exit: assert property (@(posedge clk) disable iff (sys_rst)
    powerDown && irqPending && !inProg |=> !powerDown)
    else $error("interrupt did not end power-down");
endmodule : cwd_config_decoder

// ===== sim/cwd_programmer.sv
// Behavioural programming tool that drives the APB port and the programming-mode pin.
`timescale 1ns/100ps
module cwd_programmer (
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic progModePin,
  output logic hung
);
  import cwd_pkg::*;

  // Idle bus at time zero; the tool never floats its outputs.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    progModePin = 1'b0;
    hung = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request is held until pready is seen high at an edge, for at most 50 edges.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hung <= 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // A programming session: optional write of the word, then a read-back to verify it.
  task automatic session(input logic doWrite, input logic [13:0] w, output logic [31:0] rb);
    logic [31:0] q;
    logic e;
    @(posedge clk);
    progModePin <= 1'b1;
    repeat (4) @(posedge clk); // The pin is synchronised by two flops first.
    xfer(1'b1, APB_PROG_ADDR, {18'h0_0000, CONFIG_ADDR}, q, e);
    if (doWrite) xfer(1'b1, APB_PROG_DATA, {18'h0_0000, w}, q, e);
    xfer(1'b0, APB_PROG_DATA, 32'h0000_0000, rb, e);
    progModePin <= 1'b0;
  endtask : session
endmodule : cwd_programmer

// ===== sim/config_word_decoder_tb.sv
// Self-checking testbench of the configuration word decoder.
`timescale 1ns/100ps
module config_word_decoder_tb;
  import cwd_pkg::*;
  localparam int PW = 20;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, progModePin, hung, e;
  logic powerOnPin, extResetPin, watchdogWake, irqPending, oscInputPin;
  logic [31:0] paddr, pwdata, prdata, rb;
  cwd_osc_e oscType;
  cwd_guard_e codeGuard;
  logic watchdogOn, watchdogClkSel, powerupDelayOn, brownoutOn, extClockOk, holdInReset, powerDown;
  int failures, checks_done, n;
  logic [13:0] w;
  logic [7:0] c;
  // Case fields: osc, watchdog, delay-off bit, guard, brownout, power-on.
  logic [7:0] cases [6] = '{8'hFF, 8'hC9, 8'hA7, 8'h51, 8'h3F, 8'hEE};

  cwd_config_decoder #(.PWRUP_COUNT(PW), .HAS_BROWNOUT(1'b1)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progModePin(progModePin), .powerOnPin(powerOnPin), .extResetPin(extResetPin),
    .watchdogWake(watchdogWake), .irqPending(irqPending), .oscInputPin(oscInputPin),
    .oscType(oscType), .watchdogOn(watchdogOn), .watchdogClkSel(watchdogClkSel),
    .powerupDelayOn(powerupDelayOn), .codeGuard(codeGuard), .brownoutOn(brownoutOn),
    .extClockOk(extClockOk), .holdInReset(holdInReset), .powerDown(powerDown));

  cwd_programmer i_prog (
    .clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .progModePin(progModePin), .hung(hung));

  // System clock, and an unrelated oscillator input of 24 ns period.
  always #2.5 clk = ~clk;
  always #12 oscInputPin = ~oscInputPin;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    checks_done++;
    if (got !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  // Counts cycles until the device leaves reset; a hang ends the run.
  // Sampling on the falling edge avoids racing the edge that moves the sequencer.
  task automatic wait_release(output int cnt);
    cnt = 0;
    while (holdInReset !== 1'b0 && cnt < 20000) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= 20000) begin
      failures++;
      stop_test();
    end
  endtask : wait_release

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset view, decode table, refusals, then the three wake causes.
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    powerOnPin = 1'b1;
    extResetPin = 1'b0;
    watchdogWake = 1'b0;
    irqPending = 1'b0;
    oscInputPin = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    chk("resetOsc", CWD_OSC_RC, oscType);
    chk("resetGuard", CWD_GUARD_NONE, codeGuard);
    chk("resetHold", 1, holdInReset);
    chk("wdClk", 1, watchdogClkSel);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      c = cases[i];
      w = {c[3:2], c[3:2], c[3:2], 1'b1, c[1], c[3:2], c[4], c[5], c[7:6]};
      powerOnPin <= c[0];
      i_prog.session(1'b1, w & 14'h3F7F, rb);
      chk("readback", {18'h0_0000, w}, rb);
      wait_release(n);
      if (c[7:6] != 2'b11) chk("settle", 1, n >= 4096);
      else if (!c[4] && c[0]) chk("delay", 1, n >= PW && n <= PW + 10);
      else chk("noDelay", 1, n < PW);
      chk("osc", c[7:6], oscType);
      chk("watchdog", c[5], watchdogOn);
      chk("delayOn", !c[4], powerupDelayOn);
      chk("guard", c[3:2], codeGuard);
      chk("brownout", c[1], brownoutOn);
      chk("extClk", c[7:6] != 2'b11, extClockOk);
      i_prog.xfer(1'b0, APB_CONFIG_WORD, 32'h0000_0000, rb, e);
      chk("configWord", {18'h0_0000, w}, rb);
    end
    i_prog.xfer(1'b1, APB_PROG_ADDR, {18'h0_0000, CONFIG_ADDR}, rb, e);
    i_prog.xfer(1'b0, APB_PROG_DATA, 32'h0000_0000, rb, e);
    chk("deniedRead", 1, e);
    i_prog.xfer(1'b1, APB_PROG_DATA, 32'h0000_0000, rb, e);
    i_prog.session(1'b0, 14'h0000, rb);
    chk("wordKept", {18'h0_0000, w}, rb);
    wait_release(n);
    i_prog.xfer(1'b0, 32'h0000_0020, 32'h0000_0000, rb, e);
    chk("unmappedErr", 1, e);
    chk("unmappedData", 0, rb);
    i_prog.xfer(1'b0, APB_PROG_CTRL, 32'h0000_0000, rb, e);
    chk("progCtrl", 0, rb);
    i_prog.xfer(1'b0, APB_STATUS, 32'h0000_0000, rb, e);
    chk("statusLow", 0, rb & 32'h0000_000F);
    for (int k = 0; k < 3; k++) begin
      i_prog.xfer(1'b1, APB_WAKE_CTRL, 32'h0000_0001, rb, e);
      repeat (2) @(posedge clk);
      chk("asleep", 1, powerDown);
      irqPending <= (k == 0);
      watchdogWake <= (k == 1);
      extResetPin <= (k == 2);
      n = 0;
      while (powerDown !== 1'b0 && n < 10) begin
        @(posedge clk);
        n++;
      end
      chk("awake", 0, powerDown);
      irqPending <= 1'b0;
      watchdogWake <= 1'b0;
      extResetPin <= 1'b0;
      @(posedge clk);
      wait_release(n);
    end
    chk("busHung", 0, hung);
    stop_test();
  end
endmodule : config_word_decoder_tb
